// [core_special_registers.v]
// core special-function registers: accumulator, pc low, bank pointer, flags, port a
//
// Behaviour
// - every alu result lands in the accumulator, never in data memory.
// - register writes carry the accumulator or a single-bit edit; no register-to-register move.
// - writing pc low byte jumps there, upper pc bits kept in page.
// - a pc low write is followed by one dummy instruction cycle.
// - reset returns data bank to 0, except watchdog reset while powered down.
// - special-function addresses reach the same registers in every bank.
// - direct accesses use bank 0; only indirect accesses use the bank field.
// - data bank 0 valid, 1 reserved, 2..highest valid, above undefined.
// - code bank n covers n*2000H to n*2000H+1FFFH.
// - unimplemented bank bits read zero; fields read/write, power up zero.
// - status writes never alter watchdog-expired or halt-entered flags.
// - watchdog flag clears on power-up, clear or halt; sets on time-out.
// - halt flag clears on power-up or watchdog clear; sets on halt.
// - wrap flag is carry into top bit xor carry out of it.
// - zero flag follows whether an arithmetic or logic result is zero.
// - half flag is low nibble carry, or no nibble borrow in subtraction.
// - carry is add carry out, no-borrow in subtract, and rotate-through bit.
// - interrupts and calls do not save the flags automatically.
// - flag bits 0-3 read/write, bits 7-6 read zero, power flags reset clear.
// - direction bit one makes pin input, zero makes it output.
// - single-bit set and clear on port registers leave other bits alone.
// - in idle or sleep, a selected port a falling edge wakes the device.
`timescale 1ns/1ps
`default_nettype none
`include "core_special_registers_defines.vh"

module core_special_registers (
   // clock, reset, enable
   input wire clk_sys,
   input wire reset_n,
   input wire clkEn,
   // warm reset from the system controller
   input wire sysResetPulse,
   input wire resetKeepsBank,
   // data memory access from the instruction core
   input wire [7:0] memAddr,
   input wire memIndirect,
   input wire memRd,
   input wire memWr,
   input wire memBitOp,
   input wire memBitVal,
   input wire [2:0] memBitSel,
   output reg [7:0] memRdData,
   output reg [4:0] memRamBank,
   output reg [1:0] memRamBankState,
   // alu request
   input wire aluGo,
   input wire [3:0] aluOp,
   input wire [7:0] aluOperand,
   // system instructions and watchdog
   input wire clrWdtInstr,
   input wire haltInstr,
   input wire wdtTimeout,
   // program counter
   input wire [6:0] pcCurrentHigh,
   output reg pcJump,
   output reg [14:0] pcJumpTarget,
   output reg pcDummyCycle,
   output reg [14:0] codeBankBase,
   // port a pins
   input wire [7:0] portAIn,
   output reg [7:0] portAOut,
   output reg [7:0] portAOe,
   // power mode and wake
   input wire sleepMode,
   output reg wakeUp,
   // visible core state
   output reg [7:0] accOut,
   output reg [7:0] flagsOut
);

   // ******
   // state
   // ******
   reg [7:0] working_result_reg;
   reg [7:0] working_result_next;
   reg [7:0] bank_select_reg;
   reg [3:0] arith_flags_reg;
   reg [3:0] arith_flags_next;
   reg watchdog_expired_flag_reg;
   reg halt_entered_flag_reg;
   reg [7:0] port_a_data_reg;
   reg [7:0] port_a_direction_reg;
   reg [7:0] port_a_wake_select_reg;
   reg [7:0] pinPrev_reg;
   reg jumpPending_reg;
   wire [7:0] pinStable;

   pin_sync #(.WIDTH(8)) portASync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .clkEn(clkEn),
      .pinIn(portAIn),
      .pinStable(pinStable)
   );

   // ******
   // helpers
   // ******
   function [1:0] bankDecode;
      input [4:0] field;
      begin
         if (field == 5'h00) begin
            bankDecode = `BANK_OK;
         end else if (field == `BANK_DATA_RESERVED) begin
            bankDecode = `BANK_RESERVED;
         end else if (field > `BANK_DATA_MAX) begin
            bankDecode = `BANK_UNDEFINED;
         end else begin
            bankDecode = `BANK_OK;
         end
      end
   endfunction

   function [7:0] bitUpdate;
      input [7:0] old;
      input [2:0] sel;
      input val;
      begin
         bitUpdate = old;
         bitUpdate[sel] = val;
      end
   endfunction

   // ******
   // register read mux
   // ******
   wire [4:0] data_bank_field = bank_select_reg[`BANK_DATA_MSB:0];
   wire [1:0] code_bank_field = bank_select_reg[`BANK_CODE_MSB:`BANK_CODE_LSB];
   wire [7:0] flagsView = {2'b00, watchdog_expired_flag_reg, halt_entered_flag_reg,
                           arith_flags_reg};
   // input pins show the pin, output pins show the latch
   wire [7:0] portAView = (port_a_direction_reg & pinStable) |
                          (~port_a_direction_reg & port_a_data_reg);
   reg [7:0] regView;

   // address compare ignores the bank, so every bank sees these
   always @* begin
      case (memAddr)
         `ADDR_BANK_SELECT: regView = bank_select_reg & `BANK_IMPL_MASK;
         `ADDR_WORKING_RESULT: regView = working_result_reg;
         `ADDR_PC_LOW: regView = pcJumpTarget[7:0];
         `ADDR_PROCESSOR_FLAGS: regView = flagsView;
         `ADDR_PORT_A_DATA: regView = portAView;
         `ADDR_PORT_A_DIRECTION: regView = port_a_direction_reg;
         `ADDR_PORT_A_WAKE: regView = port_a_wake_select_reg;
         default: regView = 8'h00;
      endcase
   end

   // ******
   // write data: only the accumulator or a single-bit edit
   // ******
   wire sfrWr = memWr && (memAddr < `SFR_TOP);
   // a port a bit edit starts from the latch, so pin levels never leak into it
   wire [7:0] wrBase = (memAddr == `ADDR_PORT_A_DATA) ? port_a_data_reg : regView;
   wire [7:0] wrValue = memBitOp ? bitUpdate(wrBase, memBitSel, memBitVal)
                                 : working_result_reg;

   // ******
   // alu
   // ******
   wire subOp = (aluOp == `OP_SUB) || (aluOp == `OP_SBC) || (aluOp == `OP_DEC);
   wire [7:0] addB = (aluOp == `OP_INC || aluOp == `OP_DEC) ? 8'h01 : aluOperand;
   wire [7:0] addBx = subOp ? ~addB : addB;
   wire addCin = (aluOp == `OP_ADC || aluOp == `OP_SBC) ? arith_flags_reg[`FLAG_CARRY] : subOp;
   wire [4:0] lowSum = {1'b0, working_result_reg[3:0]} + {1'b0, addBx[3:0]} + {4'h0, addCin};
   wire [3:0] midSum = {1'b0, working_result_reg[6:4]} + {1'b0, addBx[6:4]} + {3'h0, lowSum[4]};
   wire [1:0] topSum = {1'b0, working_result_reg[7]} + {1'b0, addBx[7]} + {1'b0, midSum[3]};
   wire [7:0] sum = {topSum[0], midSum[2:0], lowSum[3:0]};

   always @* begin
      working_result_next = working_result_reg;
      arith_flags_next = arith_flags_reg;
      case (aluOp)
         `OP_LOAD: working_result_next = aluOperand;
         `OP_ADD, `OP_ADC, `OP_SUB, `OP_SBC: begin
            working_result_next = sum;
            // carry out is the no-borrow bit when subtracting
            arith_flags_next[`FLAG_CARRY] = topSum[1];
            arith_flags_next[`FLAG_HALF] = lowSum[4];
            arith_flags_next[`FLAG_WRAP] = topSum[1] ^ midSum[3];
         end
         `OP_INC, `OP_DEC: working_result_next = sum;
         `OP_AND: working_result_next = working_result_reg & aluOperand;
         `OP_OR: working_result_next = working_result_reg | aluOperand;
         `OP_XOR: working_result_next = working_result_reg ^ aluOperand;
         `OP_CPL: working_result_next = ~working_result_reg;
         `OP_RLC: begin
            working_result_next = {working_result_reg[6:0], arith_flags_reg[`FLAG_CARRY]};
            arith_flags_next[`FLAG_CARRY] = working_result_reg[7];
         end
         `OP_RRC: begin
            working_result_next = {arith_flags_reg[`FLAG_CARRY], working_result_reg[7:1]};
            arith_flags_next[`FLAG_CARRY] = working_result_reg[0];
         end
         // plain rotates and clear leave every flag alone
         `OP_RL: working_result_next = {working_result_reg[6:0], working_result_reg[7]};
         `OP_RR: working_result_next = {working_result_reg[0], working_result_reg[7:1]};
         `OP_CLR: working_result_next = 8'h00;
         default: working_result_next = working_result_reg;
      endcase
      // add through dec are exactly the codes that set or clear zero
      if (aluOp >= `OP_ADD && aluOp <= `OP_DEC) begin
         arith_flags_next[`FLAG_ZERO] = (working_result_next == 8'h00);
      end
   end

   // ******
   // accumulator and arithmetic flags
   // ******
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         working_result_reg <= `RST_WORKING_RESULT;
         arith_flags_reg <= `RST_ARITH_FLAGS;
      end else if (clkEn) begin
         // a register write wins if the core ever issues both together
         if (sfrWr && memAddr == `ADDR_WORKING_RESULT) begin
            working_result_reg <= wrValue;
         end else if (aluGo) begin
            working_result_reg <= working_result_next;
         end
         if (sfrWr && memAddr == `ADDR_PROCESSOR_FLAGS) begin
            arith_flags_reg <= wrValue[3:0];
         end else if (aluGo) begin
            arith_flags_reg <= arith_flags_next;
         end
      end
   end

   // ******
   // power and watchdog flags, written by events only
   // ******
   // no path from wrValue reaches these two bits
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         watchdog_expired_flag_reg <= 1'b0;
         halt_entered_flag_reg <= 1'b0;
      end else if (clkEn) begin
         if (wdtTimeout) begin
            watchdog_expired_flag_reg <= 1'b1;
         end else if (clrWdtInstr || haltInstr) begin
            watchdog_expired_flag_reg <= 1'b0;
         end
         if (haltInstr) begin
            halt_entered_flag_reg <= 1'b1;
         end else if (clrWdtInstr) begin
            halt_entered_flag_reg <= 1'b0;
         end
      end
   end

   // ******
   // bank pointer
   // ******
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         bank_select_reg <= `RST_BANK_SELECT;
      end else if (clkEn) begin
         if (sysResetPulse) begin
            // a watchdog wake from power-down keeps the bank it had
            if (!resetKeepsBank) begin
               bank_select_reg <= `RST_BANK_SELECT;
            end
         end else if (sfrWr && memAddr == `ADDR_BANK_SELECT) begin
            bank_select_reg <= wrValue & `BANK_IMPL_MASK;
         end
      end
   end

   // ******
   // port a registers
   // ******
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         port_a_data_reg <= `RST_PORT_A_DATA;
         port_a_direction_reg <= `RST_PORT_A_DIRECTION;
         port_a_wake_select_reg <= `RST_PORT_A_WAKE;
      end else if (clkEn && sfrWr) begin
         // single-bit edits arrive here already merged into wrValue
         case (memAddr)
            `ADDR_PORT_A_DATA: port_a_data_reg <= wrValue;
            `ADDR_PORT_A_DIRECTION: port_a_direction_reg <= wrValue;
            `ADDR_PORT_A_WAKE: port_a_wake_select_reg <= wrValue;
            default: port_a_data_reg <= port_a_data_reg;
         endcase
      end
   end

   // ******
   // memory read path and ram bank steering
   // ******
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         memRdData <= 8'h00;
         memRamBank <= 5'h00;
         memRamBankState <= `BANK_OK;
      end else if (clkEn) begin
         if (memRd) begin
            memRdData <= regView;
         end
         if (memRd || memWr) begin
            if (memIndirect) begin
               memRamBank <= data_bank_field;
               memRamBankState <= bankDecode(data_bank_field);
            end else begin
               memRamBank <= 5'h00;
               memRamBankState <= `BANK_OK;
            end
         end
      end
   end

   // ******
   // program counter jump and dummy cycle
   // ******
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pcJump <= 1'b0;
         pcJumpTarget <= 15'h0000;
         pcDummyCycle <= 1'b0;
         jumpPending_reg <= 1'b0;
         codeBankBase <= 15'h0000;
      end else if (clkEn) begin
         pcJump <= 1'b0;
         if (sfrWr && memAddr == `ADDR_PC_LOW) begin
            // only the low byte moves, so the target stays in this page
            pcJump <= 1'b1;
            pcJumpTarget <= {pcCurrentHigh, wrValue};
         end
         jumpPending_reg <= sfrWr && (memAddr == `ADDR_PC_LOW);
         pcDummyCycle <= jumpPending_reg;
         codeBankBase <= {code_bank_field, 13'h0000};
      end
   end

   // ******
   // port a pins, wake-up and visible state
   // ******
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         portAOut <= `RST_PORT_A_DATA;
         portAOe <= 8'h00;
         pinPrev_reg <= 8'hFF;
         wakeUp <= 1'b0;
         accOut <= `RST_WORKING_RESULT;
         flagsOut <= 8'h00;
      end else if (clkEn) begin
         portAOut <= port_a_data_reg;
         portAOe <= ~port_a_direction_reg;
         pinPrev_reg <= pinStable;
         // wake ignores direction; only the select bit counts
         wakeUp <= sleepMode && |(pinPrev_reg & ~pinStable & port_a_wake_select_reg);
         accOut <= working_result_reg;
         // nothing here pushes flags on calls or interrupts
         flagsOut <= flagsView;
      end
   end

endmodule // core_special_registers

`default_nettype wire

// [core_special_registers_defines.vh]
// constants for the core special-function register bank
`ifndef CORE_SPECIAL_REGISTERS_DEFINES_VH
`define CORE_SPECIAL_REGISTERS_DEFINES_VH

// ******
// data memory locations
// ******
`define ADDR_BANK_SELECT 8'h04
`define ADDR_WORKING_RESULT 8'h05
`define ADDR_PC_LOW 8'h06
`define ADDR_PROCESSOR_FLAGS 8'h0A
`define ADDR_PORT_A_DATA 8'h12
`define ADDR_PORT_A_DIRECTION 8'h13
`define ADDR_PORT_A_WAKE 8'h29
`define SFR_TOP 8'h40

// ******
// field layouts
// ******
`define BANK_DATA_MSB 4
`define BANK_CODE_LSB 5
`define BANK_CODE_MSB 6
`define BANK_IMPL_MASK 8'h7F
`define BANK_DATA_MAX 5'h12
`define BANK_DATA_RESERVED 5'h01
`define FLAG_CARRY 0
`define FLAG_HALF 1
`define FLAG_ZERO 2
`define FLAG_WRAP 3
`define FLAG_HALT 4
`define FLAG_WDT 5

// ******
// reset values
// ******
`define RST_BANK_SELECT 8'h00
`define RST_WORKING_RESULT 8'h00
`define RST_ARITH_FLAGS 4'h0
`define RST_PORT_A_DATA 8'h00
`define RST_PORT_A_DIRECTION 8'hFF
`define RST_PORT_A_WAKE 8'h00

// ******
// bank decode answers
// ******
`define BANK_OK 2'h0
`define BANK_RESERVED 2'h1
`define BANK_UNDEFINED 2'h2

// ******
// alu operation codes
// ******
`define OP_LOAD 4'h0
`define OP_ADD 4'h1
`define OP_ADC 4'h2
`define OP_SUB 4'h3
`define OP_SBC 4'h4
`define OP_AND 4'h5
`define OP_OR 4'h6
`define OP_XOR 4'h7
`define OP_CPL 4'h8
`define OP_INC 4'h9
`define OP_DEC 4'hA
`define OP_RLC 4'hB
`define OP_RRC 4'hC
`define OP_RL 4'hD
`define OP_RR 4'hE
`define OP_CLR 4'hF

`endif

// [pin_sync.v]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter WIDTH = 8
) (
   // clock and reset
   input wire clk_sys,
   input wire reset_n,
   input wire clkEn,
   // pins in, settled value out
   input wire [WIDTH-1:0] pinIn,
   output reg [WIDTH-1:0] pinStable
);

   reg [WIDTH-1:0] stage1_reg;
   reg [WIDTH-1:0] stage2_reg;
   reg [WIDTH-1:0] stage3_reg;
   integer i;

   // stage1 is read by stage2 only; a bit moves once stages 2 and 3 agree
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         stage1_reg <= {WIDTH{1'b1}};
         stage2_reg <= {WIDTH{1'b1}};
         stage3_reg <= {WIDTH{1'b1}};
         pinStable <= {WIDTH{1'b1}};
      end else if (clkEn) begin
         stage1_reg <= pinIn;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         for (i = 0; i < WIDTH; i = i + 1) begin
            if (stage2_reg[i] == stage3_reg[i]) begin
               pinStable[i] <= stage3_reg[i];
            end
         end
      end
   end

endmodule // pin_sync

`default_nettype wire

// [core_special_registers_monitor.sv]
// assertion checker for the core special-function register bank
`timescale 1ns/1ps
`default_nettype none
`include "core_special_registers_defines.vh"
module core_special_registers_monitor (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clkEn,
   // memory access
   input wire logic [7:0] memAddr,
   input wire logic memIndirect,
   input wire logic memRd,
   input wire logic memWr,
   input wire logic memBitOp,
   input wire logic [4:0] memRamBank,
   input wire logic [1:0] memRamBankState,
   // alu and system events
   input wire logic aluGo,
   input wire logic [3:0] aluOp,
   input wire logic [7:0] aluOperand,
   input wire logic clrWdtInstr,
   input wire logic haltInstr,
   input wire logic wdtTimeout,
   // program counter, wake, visible state
   input wire logic [6:0] pcCurrentHigh,
   input wire logic pcJump,
   input wire logic [14:0] pcJumpTarget,
   input wire logic pcDummyCycle,
   input wire logic sleepMode,
   input wire logic wakeUp,
   input wire logic [7:0] accOut,
   input wire logic [7:0] flagsOut
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   // ******
   // assertions
   // ******
   a_jump_on_write: assert property (
      clkEn && memWr && !memBitOp && memAddr == `ADDR_PC_LOW
      |=> pcJump && pcJumpTarget[14:8] == $past(pcCurrentHigh))
      else $error("pc low write gave no jump in page");
   a_dummy_after_jump: assert property (pcJump && clkEn |=> pcDummyCycle)
      else $error("no dummy cycle after jump");
   a_direct_bank_zero: assert property (
      clkEn && (memRd || memWr) && !memIndirect
      |=> memRamBank == 5'h00 && memRamBankState == `BANK_OK)
      else $error("direct access left bank 0");
   a_bank_decode_state: assert property (
      memRamBankState == (memRamBank == `BANK_DATA_RESERVED ? `BANK_RESERVED :
      (memRamBank > `BANK_DATA_MAX ? `BANK_UNDEFINED : `BANK_OK)))
      else $error("bank state does not match bank");
   a_flags_top_zero: assert property (flagsOut[7:6] == 2'h0)
      else $error("flag bits 7-6 not zero");
   // a coincident write would win, so it is excluded
   a_load_to_acc: assert property (
      clkEn && aluGo && aluOp == `OP_LOAD && !memWr |-> ##2 accOut == $past(aluOperand, 2))
      else $error("alu result missing from accumulator");
   a_load_keeps_flags: assert property (
      clkEn && aluGo && aluOp == `OP_LOAD && !memWr |-> ##2 $stable(flagsOut[3:0]))
      else $error("load changed arithmetic flags");
   a_wdt_sets_flag: assert property (clkEn && wdtTimeout |-> ##2 flagsOut[`FLAG_WDT])
      else $error("time-out did not set watchdog flag");
   a_halt_sets_flag: assert property (
      clkEn && haltInstr && !wdtTimeout |-> ##2 flagsOut[5:4] == 2'h1)
      else $error("halt flags wrong");
   a_clear_power_flags: assert property (
      clkEn && clrWdtInstr && !haltInstr && !wdtTimeout |-> ##2 flagsOut[5:4] == 2'h0)
      else $error("watchdog clear left power flags set");
   a_power_flags_cause: assert property (
      $changed(flagsOut[5:4])
      |-> $past(clrWdtInstr, 2) || $past(haltInstr, 2) || $past(wdtTimeout, 2))
      else $error("power flags changed without an event");
   a_wake_in_sleep: assert property (wakeUp |-> $past(sleepMode))
      else $error("wake pulse while awake");
   c_jump: cover property (pcJump);
   c_reserved_bank: cover property (memRamBankState == `BANK_RESERVED);
   c_wake: cover property (wakeUp);
endmodule // core_special_registers_monitor

bind core_special_registers core_special_registers_monitor core_special_registers_monitor_i (
   .clk_sys(clk_sys), .reset_n(reset_n), .clkEn(clkEn), .memAddr(memAddr),
   .memIndirect(memIndirect), .memRd(memRd), .memWr(memWr), .memBitOp(memBitOp),
   .memRamBank(memRamBank), .memRamBankState(memRamBankState), .aluGo(aluGo),
   .aluOp(aluOp), .aluOperand(aluOperand), .clrWdtInstr(clrWdtInstr),
   .haltInstr(haltInstr), .wdtTimeout(wdtTimeout), .pcCurrentHigh(pcCurrentHigh),
   .pcJump(pcJump), .pcJumpTarget(pcJumpTarget), .pcDummyCycle(pcDummyCycle),
   .sleepMode(sleepMode), .wakeUp(wakeUp), .accOut(accOut), .flagsOut(flagsOut));
`default_nettype wire

// [core_special_registers_tb_top.sv]
// self-checking bench for the core special-function register bank
`timescale 1ns/1ps
`default_nettype none
`include "core_special_registers_defines.vh"
module core_special_registers_tb_top;
   // ******
   // stimulus and observed signals
   // ******
   logic clk_sys = 1'b0, clkEn = 1'b1;
   logic reset_n = 1'b0;
   logic sysResetPulse = 1'b0, resetKeepsBank = 1'b0, memIndirect = 1'b0, memRd = 1'b0;
   logic memWr = 1'b0, memBitOp = 1'b0, memBitVal = 1'b0, aluGo = 1'b0, sleepMode = 1'b0;
   logic clrWdtInstr = 1'b0, haltInstr = 1'b0, wdtTimeout = 1'b0;
   logic [2:0] memBitSel = 3'h0;
   logic [3:0] aluOp = 4'h0;
   logic [6:0] pcCurrentHigh = 7'h12;
   logic [7:0] memAddr = 8'h00, aluOperand = 8'h00, portAIn = 8'hFF, d;
   wire [7:0] memRdData, portAOut, portAOe, accOut, flagsOut;
   wire [4:0] memRamBank;
   wire [1:0] memRamBankState;
   wire [14:0] pcJumpTarget, codeBankBase;
   wire pcJump, pcDummyCycle, wakeUp;
   int num_errors = 0, num_checks = 0, wakes = 0;
   logic [7:0] bankVals [5] = '{8'h01, 8'h13, 8'h1F, 8'h02, 8'h12};
   logic [1:0] bankStates [5] = '{`BANK_RESERVED, `BANK_UNDEFINED, `BANK_UNDEFINED,
      `BANK_OK, `BANK_OK};

   core_special_registers core_special_registers_i (
      .clk_sys(clk_sys), .reset_n(reset_n), .clkEn(clkEn), .sysResetPulse(sysResetPulse),
      .resetKeepsBank(resetKeepsBank), .memAddr(memAddr), .memIndirect(memIndirect),
      .memRd(memRd), .memWr(memWr), .memBitOp(memBitOp), .memBitVal(memBitVal),
      .memBitSel(memBitSel), .memRdData(memRdData), .memRamBank(memRamBank),
      .memRamBankState(memRamBankState), .aluGo(aluGo), .aluOp(aluOp),
      .aluOperand(aluOperand), .clrWdtInstr(clrWdtInstr), .haltInstr(haltInstr),
      .wdtTimeout(wdtTimeout), .pcCurrentHigh(pcCurrentHigh), .pcJump(pcJump),
      .pcJumpTarget(pcJumpTarget), .pcDummyCycle(pcDummyCycle),
      .codeBankBase(codeBankBase), .portAIn(portAIn), .portAOut(portAOut),
      .portAOe(portAOe), .sleepMode(sleepMode), .wakeUp(wakeUp), .accOut(accOut),
      .flagsOut(flagsOut));

   always #4 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (wakeUp === 1'b1) begin
         wakes <= wakes + 1;
      end
   end
   // ******
   // access tasks
   // ******
   task automatic check(input string what, input [15:0] exp, input [15:0] seen);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic settle();
      @(posedge clk_sys);
      #1;
   endtask
   // write data is the accumulator, so put loads it first
   task automatic wr(input [7:0] a, input bo = 1'b0, input [2:0] sel = 3'h0, input v = 1'b0);
      @(posedge clk_sys);
      memAddr <= a;
      memWr <= 1'b1;
      memBitOp <= bo;
      memBitSel <= sel;
      memBitVal <= v;
      @(posedge clk_sys);
      memWr <= 1'b0;
      memBitOp <= 1'b0;
   endtask
   task automatic rd(input [7:0] a, input ind);
      @(posedge clk_sys);
      memAddr <= a;
      memIndirect <= ind;
      memRd <= 1'b1;
      @(posedge clk_sys);
      memRd <= 1'b0;
      settle();
      d = memRdData;
   endtask
   task automatic rdchk(input [7:0] a, input ind, input [7:0] exp);
      rd(a, ind);
      check($sformatf("read %h", a), exp, d);
   endtask
   task automatic alu(input [3:0] op, input [7:0] v);
      @(posedge clk_sys);
      aluGo <= 1'b1;
      aluOp <= op;
      aluOperand <= v;
      @(posedge clk_sys);
      aluGo <= 1'b0;
   endtask
   task automatic step(input [3:0] op, input [7:0] v, input [7:0] ea, input [3:0] ef);
      alu(op, v);
      @(posedge clk_sys);
      settle();
      check("accumulator", ea, accOut);
      check("arith flags", ef, flagsOut[3:0]);
   endtask
   task automatic put(input [7:0] a, input [7:0] v);
      alu(`OP_LOAD, v);
      wr(a);
      settle();
   endtask
   task automatic evt(input [2:0] m);
      @(posedge clk_sys);
      {wdtTimeout, haltInstr, clrWdtInstr} <= m;
      @(posedge clk_sys);
      {wdtTimeout, haltInstr, clrWdtInstr} <= 3'h0;
   endtask
   task automatic warm(input keep, input [7:0] exp);
      @(posedge clk_sys);
      sysResetPulse <= 1'b1;
      resetKeepsBank <= keep;
      @(posedge clk_sys);
      sysResetPulse <= 1'b0;
      rdchk(`ADDR_BANK_SELECT, 1'b0, exp);
   endtask
   task automatic pin(input [7:0] v);
      @(posedge clk_sys);
      portAIn <= v;
      repeat (10) @(posedge clk_sys);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ******
   // tests
   // ******
   initial begin
      repeat (20) @(posedge clk_sys);
      reset_n <= 1'b1;
      rdchk(`ADDR_BANK_SELECT, 1'b0, 8'h00);
      rdchk(`ADDR_PROCESSOR_FLAGS, 1'b0, 8'h00);
      rdchk(`ADDR_PORT_A_DIRECTION, 1'b0, 8'hFF);
      rdchk(8'h3E, 1'b0, 8'h00);
      check("pin enables", 8'h00, portAOe);
      $display("test reset done");
      step(`OP_LOAD, 8'h7F, 8'h7F, 4'h0);
      step(`OP_ADD, 8'h01, 8'h80, 4'hA);
      step(`OP_ADD, 8'h80, 8'h00, 4'hD);
      step(`OP_ADC, 8'h01, 8'h02, 4'h0);
      step(`OP_SUB, 8'h03, 8'hFF, 4'h0);
      step(`OP_SBC, 8'h01, 8'hFD, 4'h3);
      step(`OP_AND, 8'h0F, 8'h0D, 4'h3);
      step(`OP_OR, 8'hF0, 8'hFD, 4'h3);
      step(`OP_XOR, 8'hFD, 8'h00, 4'h7);
      step(`OP_RLC, 8'h00, 8'h01, 4'h6);
      step(`OP_RRC, 8'h00, 8'h00, 4'h7);
      step(`OP_LOAD, 8'h81, 8'h81, 4'h7);
      step(`OP_RL, 8'h00, 8'h03, 4'h7);
      step(`OP_RR, 8'h00, 8'h81, 4'h7);
      step(`OP_CLR, 8'h00, 8'h00, 4'h7);
      step(`OP_CPL, 8'h00, 8'hFF, 4'h3);
      step(`OP_INC, 8'h00, 8'h00, 4'h7);
      step(`OP_DEC, 8'h00, 8'hFF, 4'h3);
      @(posedge clk_sys) clkEn <= 1'b0;
      step(`OP_LOAD, 8'h55, 8'hFF, 4'h3);
      @(posedge clk_sys) clkEn <= 1'b1;
      $display("test alu done");
      alu(`OP_LOAD, 8'h34);
      wr(`ADDR_PC_LOW);
      #1;
      check("jump", 1'b1, pcJump);
      check("jump target", 15'h1234, pcJumpTarget);
      settle();
      check("dummy cycle", 1'b1, pcDummyCycle);
      check("jump", 1'b0, pcJump);
      $display("test jump done");
      put(`ADDR_BANK_SELECT, 8'h52);
      rdchk(`ADDR_BANK_SELECT, 1'b0, 8'h52);
      check("code base", 15'h4000, codeBankBase);
      rd(8'h40, 1'b1);
      check("bank", 5'h12, memRamBank);
      rd(8'h40, 1'b0);
      check("bank", 5'h00, memRamBank);
      rdchk(`ADDR_PROCESSOR_FLAGS, 1'b1, 8'h03);
      for (int i = 0; i < 5; i++) begin
         put(`ADDR_BANK_SELECT, bankVals[i]);
         rd(8'h40, 1'b1);
         check("bank", bankVals[i][4:0], memRamBank);
         check("bank state", bankStates[i], memRamBankState);
      end
      put(`ADDR_BANK_SELECT, 8'hFF);
      check("code base", 15'h6000, codeBankBase);
      warm(1'b1, 8'h7F);
      warm(1'b0, 8'h00);
      $display("test bank done");
      put(`ADDR_PROCESSOR_FLAGS, 8'hFF);
      rdchk(`ADDR_PROCESSOR_FLAGS, 1'b0, 8'h0F);
      evt(3'h4);
      rdchk(`ADDR_PROCESSOR_FLAGS, 1'b0, 8'h2F);
      put(`ADDR_PROCESSOR_FLAGS, 8'h00);
      rdchk(`ADDR_PROCESSOR_FLAGS, 1'b0, 8'h20);
      evt(3'h2);
      rdchk(`ADDR_PROCESSOR_FLAGS, 1'b0, 8'h10);
      evt(3'h1);
      rdchk(`ADDR_PROCESSOR_FLAGS, 1'b0, 8'h00);
      $display("test flags done");
      put(`ADDR_PORT_A_DIRECTION, 8'h0F);
      check("pin enables", 8'hF0, portAOe);
      put(`ADDR_PORT_A_DATA, 8'hA5);
      wr(`ADDR_PORT_A_DATA, 1'b1, 3'h0, 1'b0);
      wr(`ADDR_PORT_A_DIRECTION, 1'b1, 3'h3, 1'b0);
      wr(`ADDR_PORT_A_DIRECTION, 1'b1, 3'h6, 1'b1);
      settle();
      check("pin outputs", 8'hA4, portAOut);
      check("pin enables", 8'hB8, portAOe);
      rdchk(`ADDR_PORT_A_DATA, 1'b0, 8'hE7);
      put(`ADDR_PORT_A_WAKE, 8'h02);
      // an awake device and an unselected pin must both stay silent
      pin(8'hFD);
      pin(8'hFF);
      sleepMode <= 1'b1;
      pin(8'hFE);
      pin(8'hFC);
      check("wake count", 16'h0001, wakes[15:0]);
      $display("test port done");
      tally_and_finish();
   end
   initial begin
      #(8 * 20000);
      num_errors++;
      tally_and_finish();
   end
endmodule // core_special_registers_tb_top
`default_nettype wire
